// ===== design/fcb_pkg.sv
// constants and types for the flag conditional relative branch unit
package fcb_pkg;

    // ****************************************************************
    // opcode upper bytes
    // ****************************************************************
    localparam logic [7:0] OP_CARRY_CLEAR = 8'he3;
    localparam logic [7:0] OP_SIGN_CLEAR  = 8'he7;
    localparam logic [7:0] OP_NO_OVERFLOW = 8'he5;
    localparam logic [7:0] OP_SIGN_SET    = 8'he6;

    // ****************************************************************
    // instruction field positions
    // ****************************************************************
    localparam int OPCODE_MSB = 15;
    localparam int OPCODE_LSB = 8;
    localparam int OFFSET_MSB = 7;
    localparam int OFFSET_LSB = 0;
    localparam int OFFSET_W   = 8;

    // ****************************************************************
    // timing and reset values
    // ****************************************************************
    localparam logic [1:0] PHASE_Q1    = 2'h0;
    localparam logic [1:0] PHASE_Q2    = 2'h1;
    localparam logic [1:0] PHASE_Q3    = 2'h2;
    localparam logic [1:0] PHASE_Q4    = 2'h3;
    localparam logic [1:0] PHASE_RESET = PHASE_Q1;
    localparam int         PC_STEP     = 2;
    localparam int         PC_W_DEF    = 21;

    // ****************************************************************
    // sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        FCB_IDLE = 3'b001,
        FCB_EXEC = 3'b010,
        FCB_NOP  = 3'b100
    } fcb_state_e;

endpackage

// ===== design/fcb_dec_if.sv
// carrier between sequencer and condition decoder
`timescale 1ns/100ps
`default_nettype none
interface fcb_dec_if #(parameter int PC_W = 21);
    logic [15:0]     instr;
    logic            carry;
    logic            negative;
    logic            overflow;
    logic [PC_W-1:0] pcBase;
    logic            match;
    logic            taken;
    logic [PC_W-1:0] target;
    logic [PC_W-1:0] pcSeq;

    // ****************************************************************
    // views
    // ****************************************************************
    modport seq (output instr, carry, negative, overflow, pcBase,
                 input  match, taken, target, pcSeq);
    modport dec (input  instr, carry, negative, overflow, pcBase,
                 output match, taken, target, pcSeq);
endinterface
`default_nettype wire

// ===== design/fcb_cond_decode.sv
// opcode match, flag condition test and target address arithmetic
`timescale 1ns/100ps
`default_nettype none
module fcb_cond_decode
    import fcb_pkg::*;
#(
    parameter int PC_W = PC_W_DEF
) (
    // decode carrier
    fcb_dec_if.dec bus
);
    logic [7:0]          opcode;
    logic signed [OFFSET_W-1:0] offset;
    logic [PC_W-1:0]     offsetWords;

    assign opcode = bus.instr[OPCODE_MSB:OPCODE_LSB];
    assign offset = bus.instr[OFFSET_MSB:OFFSET_LSB];

    // condition per opcode
    always_comb begin
        bus.match = 1'b1;
        bus.taken = 1'b0;
        unique case (opcode)
            OP_CARRY_CLEAR: bus.taken = ~bus.carry;
            OP_SIGN_CLEAR:  bus.taken = ~bus.negative;
            OP_NO_OVERFLOW: bus.taken = ~bus.overflow;
            OP_SIGN_SET:    bus.taken = bus.negative;
            default:        bus.match = 1'b0;
        endcase
    end

    // doubled sign-extended offset, added to incremented pc
    assign offsetWords = PC_W'({{(PC_W-OFFSET_W){offset[OFFSET_W-1]}},
                                offset} << 1);
    assign bus.pcSeq   = bus.pcBase + PC_W'(PC_STEP);
    assign bus.target  = bus.pcSeq + offsetWords;
endmodule
`default_nettype wire

// ===== design/fcb_branch_unit.sv
// four-phase sequencer for the flag conditional relative branches
`timescale 1ns/100ps
`default_nettype none
module fcb_branch_unit
    import fcb_pkg::*;
#(
    parameter int PC_W = PC_W_DEF
) (
    // clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst,
    // instruction issue
    input  wire logic            instrValid,
    input  wire logic [15:0]     instrWord,
    input  wire logic [PC_W-1:0] instrAddr,
    // status flags
    input  wire logic            flagCarry,
    input  wire logic            flagNegative,
    input  wire logic            flagOverflow,
    // phase and occupancy
    output var  logic [1:0]      qPhase,
    output var  logic            busy,
    output var  logic            isBranch,
    // program counter update
    output var  logic            pcLoad,
    output var  logic            pcAdvance,
    output var  logic [PC_W-1:0] pcNext,
    output var  logic            branchTaken,
    output var  logic            flagWrite
);
    fcb_dec_if #(.PC_W(PC_W)) dec ();

    fcb_state_e      state;
    logic [15:0]     instrReg;
    logic [PC_W-1:0] addrReg;
    logic [2:0]      flagsReg;
    logic [OFFSET_W-1:0] offsetReg;
    logic            matchReg;
    logic            takenReg;
    logic [PC_W-1:0] targetReg;
    logic [PC_W-1:0] seqReg;
    logic            accept;

    fcb_cond_decode #(.PC_W(PC_W)) u_decode (
        .bus (dec)
    );

    // ****************************************************************
    // decoder inputs from latched issue
    // ****************************************************************
    assign dec.instr    = {instrReg[OPCODE_MSB:OPCODE_LSB], offsetReg};
    assign dec.carry    = flagsReg[0];
    assign dec.negative = flagsReg[1];
    assign dec.overflow = flagsReg[2];
    assign dec.pcBase   = addrReg;

    assign accept = instrValid && (qPhase == PHASE_Q1)
                    && (state == FCB_IDLE);

    // ****************************************************************
    // phase clock: one instruction cycle is four clocks
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            qPhase <= PHASE_RESET;
        end else begin
            qPhase <= qPhase + 2'h1;
        end
    end

    // ****************************************************************
    // sequencer state
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= FCB_IDLE;
        end else begin
            unique case (state)
                FCB_IDLE: begin
                    if (accept) begin
                        state <= FCB_EXEC;
                    end
                end
                FCB_EXEC: begin
                    if (qPhase == PHASE_Q4) begin
                        if (matchReg && takenReg) begin
                            state <= FCB_NOP;
                        end else begin
                            state <= FCB_IDLE;
                        end
                    end
                end
                FCB_NOP: begin
                    if (qPhase == PHASE_Q4) begin
                        state <= FCB_IDLE;
                    end
                end
                default: state <= FCB_IDLE;
            endcase
        end
    end

    // Q1: decode, capture word, address and flags
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            instrReg <= 16'h0000;
            addrReg  <= '0;
            flagsReg <= 3'h0;
        end else if (accept) begin
            instrReg <= instrWord;
            addrReg  <= instrAddr;
            flagsReg <= {flagOverflow, flagNegative, flagCarry};
        end
    end

    // Q2: read the literal offset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            offsetReg <= '0;
        end else if (state == FCB_EXEC && qPhase == PHASE_Q2) begin
            offsetReg <= instrReg[OFFSET_MSB:OFFSET_LSB];
        end
    end

    // Q3: process data, evaluate condition and target
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            matchReg  <= 1'b0;
            takenReg  <= 1'b0;
            targetReg <= '0;
            seqReg    <= '0;
        end else if (state == FCB_EXEC && qPhase == PHASE_Q3) begin
            matchReg  <= dec.match;
            takenReg  <= dec.taken;
            targetReg <= dec.target;
            seqReg    <= dec.pcSeq;
        end
    end

    // Q4: write pc when taken, else sequential advance
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pcLoad      <= 1'b0;
            pcAdvance   <= 1'b0;
            pcNext      <= '0;
            branchTaken <= 1'b0;
        end else begin
            pcLoad    <= 1'b0;
            pcAdvance <= 1'b0;
            if (state == FCB_EXEC && qPhase == PHASE_Q4) begin
                branchTaken <= matchReg && takenReg;
                if (matchReg && takenReg) begin
                    pcLoad <= 1'b1;
                    pcNext <= targetReg;
                end else begin
                    pcAdvance <= 1'b1;
                    pcNext    <= seqReg;
                end
            end
        end
    end

    // occupancy and decode flags
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy      <= 1'b0;
            isBranch  <= 1'b0;
            flagWrite <= 1'b0;
        end else begin
            busy      <= (state != FCB_IDLE) || accept;
            isBranch  <= (state == FCB_EXEC) && (qPhase == PHASE_Q4)
                         && matchReg;
            flagWrite <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== sim/fcb_branch_unit_sva.sv
// port assertions for the flag conditional branch unit
`timescale 1ns/100ps
`default_nettype none
module fcb_branch_sva
    import fcb_pkg::*;
#(parameter int PC_W = PC_W_DEF) (
    // clock and reset
    input wire logic            clk_sys,
    input wire logic            rst,
    // issue and flags
    input wire logic            instrValid,
    input wire logic [15:0]     instrWord,
    input wire logic [PC_W-1:0] instrAddr,
    input wire logic            flagCarry,
    input wire logic            flagNegative,
    input wire logic            flagOverflow,
    // results
    input wire logic [1:0]      qPhase,
    input wire logic            busy,
    input wire logic            isBranch,
    input wire logic            pcLoad,
    input wire logic            pcAdvance,
    input wire logic [PC_W-1:0] pcNext,
    input wire logic            branchTaken,
    input wire logic            flagWrite
);
    // ****************************************************************
    // accept strobe and expected outcome
    // ****************************************************************
    logic [7:0]      op;
    logic            acc;
    logic            go;
    logic [PC_W-1:0] want;
    assign op = instrWord[15:8];
    assign acc = instrValid && qPhase == PHASE_Q1 && !busy;
    assign go = (op == OP_CARRY_CLEAR && !flagCarry)
        || (op == OP_SIGN_CLEAR && !flagNegative)
        || (op == OP_NO_OVERFLOW && !flagOverflow)
        || (op == OP_SIGN_SET && flagNegative);
    assign want = instrAddr + PC_W'(2) + (go ? {{(PC_W-9){instrWord[7]}},
        instrWord[7:0], 1'b0} : PC_W'(0));
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_CARRY_CLEAR: assert property (
        acc && op == OP_CARRY_CLEAR |-> ##4 pcLoad == !$past(flagCarry, 4))
        else $error("carry clear decision wrong");
    AST_SIGN_CLEAR: assert property (
        acc && op == OP_SIGN_CLEAR |-> ##4 pcLoad == !$past(flagNegative, 4))
        else $error("sign clear decision wrong");
    AST_NO_OVERFLOW: assert property (
        acc && op == OP_NO_OVERFLOW |-> ##4 pcLoad == !$past(flagOverflow, 4))
        else $error("no overflow decision wrong");
    AST_SIGN_SET: assert property (
        acc && op == OP_SIGN_SET |-> ##4 pcLoad == $past(flagNegative, 4))
        else $error("sign set decision wrong");
    AST_TARGET: assert property (
        acc |-> ##4 pcNext == $past(want, 4))
        else $error("next pc value wrong");
    AST_FALL_THROUGH: assert property (
        acc && !go |-> ##4 pcAdvance && !pcLoad && !branchTaken)
        else $error("fall through not signalled");
    AST_BUSY_HOLD: assert property (
        acc |=> busy [*3])
        else $error("busy dropped inside cycle");
    AST_NOP_CYCLE: assert property (
        acc && go |-> ##5 busy [*3])
        else $error("idle cycle missing");
    AST_PULSE_PHASE: assert property (
        pcLoad || pcAdvance |-> qPhase == PHASE_Q1 ##1 !(pcLoad || pcAdvance))
        else $error("pc write pulse misplaced");
    AST_NO_FLAG: assert property (
        !flagWrite)
        else $error("flag write seen");
    // main scenarios
    cover property (acc && go);
    cover property (acc && !go && isBranch == 1'b0);
    cover property (acc && op == 8'h12);
endmodule
bind fcb_branch_unit fcb_branch_sva #(.PC_W(PC_W)) u_sva (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .instrValid   (instrValid),
    .instrWord    (instrWord),
    .instrAddr    (instrAddr),
    .flagCarry    (flagCarry),
    .flagNegative (flagNegative),
    .flagOverflow (flagOverflow),
    .qPhase       (qPhase),
    .busy         (busy),
    .isBranch     (isBranch),
    .pcLoad       (pcLoad),
    .pcAdvance    (pcAdvance),
    .pcNext       (pcNext),
    .branchTaken  (branchTaken),
    .flagWrite    (flagWrite)
);
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the flag conditional branch unit
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import fcb_pkg::*;
;
    localparam int W = 21;
    logic         clk_sys, rst, instrValid, flagCarry, flagNegative;
    logic         flagOverflow, busy, isBranch, pcLoad, pcAdvance;
    logic         branchTaken, flagWrite;
    logic [15:0]  instrWord;
    logic [W-1:0] instrAddr, pcNext;
    logic [1:0]   qPhase;
    logic [7:0]   ops [5];
    int           mismatches, compares, cycles, seed, n, r, s;
    fcb_branch_unit #(.PC_W(W)) dut (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .instrValid   (instrValid),
        .instrWord    (instrWord),
        .instrAddr    (instrAddr),
        .flagCarry    (flagCarry),
        .flagNegative (flagNegative),
        .flagOverflow (flagOverflow),
        .qPhase       (qPhase),
        .busy         (busy),
        .isBranch     (isBranch),
        .pcLoad       (pcLoad),
        .pcAdvance    (pcAdvance),
        .pcNext       (pcNext),
        .branchTaken  (branchTaken),
        .flagWrite    (flagWrite)
    );
    // ****************************************************************
    // clock, timeout and helpers
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            give_verdict;
        end
    end
    task automatic chk(input string nm, input logic [W-1:0] e,
                       input logic [W-1:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic logic expGo(logic [15:0] w, logic [2:0] f);
        case (w[15:8])
            OP_CARRY_CLEAR: return !f[2];
            OP_SIGN_CLEAR:  return !f[1];
            OP_NO_OVERFLOW: return !f[0];
            OP_SIGN_SET:    return f[1];
            default:        return 1'b0;
        endcase
    endfunction
    function automatic logic [W-1:0] expPc(logic [W-1:0] a, logic [7:0] o,
                                           logic g);
        logic [W-1:0] off;
        off = W'(signed'(o)); // sign extended offset
        return g ? a + W'(2) + (off << 1) : a + W'(2);
    endfunction
    // one issue, held until accepted, then the answer is checked
    task automatic run(input logic [15:0] w, input logic [W-1:0] a,
                       input logic [2:0] f, input logic tail);
        logic g;
        logic was;
        int   k;
        g = expGo(w, f);
        // a taken branch keeps busy high through its idle cycle: let it end
        for (k = 0; k < 20 && busy !== 1'b0; k++)
            @(negedge clk_sys);
        was = busy;
        @(posedge clk_sys);
        instrValid <= 1'b1;
        instrWord <= w;
        instrAddr <= a;
        {flagCarry, flagNegative, flagOverflow} <= f;
        for (k = 0; k < 40 && !(busy === 1'b1 && !was); k++) begin
            was = busy;
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
        instrValid <= 1'b0;
        for (k = 0; k < 9 && pcLoad !== 1'b1 && pcAdvance !== 1'b1; k++)
            @(negedge clk_sys);
        chk("latency", 3, W'(k));
        chk("pcLoad", g, pcLoad);
        chk("pcAdvance", !g, pcAdvance);
        chk("pcNext", expPc(a, w[7:0], g), pcNext);
        chk("isBranch", w[15:12] == 4'he && w[11:8] inside {3, 5, 6, 7},
            isBranch);
        chk("branchTaken", g, branchTaken);
        chk("qPhase", W'(PHASE_Q1), qPhase);
        chk("flagWrite", 1'b0, flagWrite);
        if (tail) begin
            k = 0;
            repeat (6) begin
                @(negedge clk_sys);
                if (busy === 1'b1) k++;
            end
            chk("idleCycle", 1'b1, g ? k == 4 : k == 0);
        end
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        seed = 32'h4e38;
        rst = 1'b1;
        instrValid = 1'b0;
        instrWord = 16'h0;
        instrAddr = '0;
        {flagCarry, flagNegative, flagOverflow} = 3'h0;
        ops = '{OP_CARRY_CLEAR, OP_NO_OVERFLOW, OP_SIGN_SET, OP_SIGN_CLEAR,
                8'h12};
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (8) @(negedge clk_sys);
        for (n = 0; n < 80; n++) begin
            r = $random(seed);
            s = $random(seed);
            if (n < 8) r[7:0] = n[1] ? (n[0] ? 8'h7f : 8'h80) : {8{n[0]}};
            if (n % 7 == 0) s = 21'h1ffffe; // wrap of the address space
            run({ops[n % 5], r[7:0]}, s[W-1:0],
                n < 40 ? n[2:0] : r[10:8], n[3]);
        end
        give_verdict;
    end
endmodule
`default_nettype wire
